// ---- sbsc_defs.vh ----
// Constants for the synchronous burst SRAM bus control front end
`ifndef SBSC_DEFS_VH
`define SBSC_DEFS_VH
`define SBSC_ADDR_W 21
`define SBSC_DATA_W 36
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_BURST_W 2
`define SBSC_RST_ADDR 21'h000000
`define SBSC_RST_DATA 36'h000000000
`define SBSC_RST_BURST 2'h0
`define SBSC_RST_LANES 4'h0
`endif

// ---- sbsc_bus_control.v ----
// Bus control front end of a synchronous flow-through burst SRAM
`timescale 1ns/10ps
`default_nettype none
`include "sbsc_defs.vh"

module sbsc_bus_control (
    input wire core_clk,
    input wire rst_n,
    input wire chip_select_a_n,
    input wire chip_select_b,
    input wire chip_select_c_n,
    input wire processor_addr_strobe_n,
    input wire controller_addr_strobe_n,
    input wire burst_advance_n,
    input wire byte_write_enable_n,
    input wire [`SBSC_LANES-1:0] byte_lane_write_n,
    input wire global_write_n,
    input wire output_enable_n,
    input wire burst_mode_interleaved,
    input wire sleep_request,
    input wire sleep_request_driven,
    input wire [`SBSC_ADDR_W-1:0] addr_in,
    input wire [`SBSC_DATA_W-1:0] data_in,
    input wire [`SBSC_DATA_W-1:0] read_data,
    output wire [`SBSC_DATA_W-1:0] data_out,
    output wire data_oe,
    output reg [`SBSC_ADDR_W-1:0] mem_addr_reg,
    output reg [`SBSC_DATA_W-1:0] write_data_reg,
    output reg [`SBSC_LANES-1:0] lane_write_reg,
    output reg access_valid_reg,
    output reg access_write_reg,
    output reg sleep_active_reg
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: pins arrive from outside the clock domain
reg [1:0] ce_a_sync;
reg [1:0] ce_b_sync;
reg [1:0] ce_c_sync;
reg [1:0] processor_addr_strobe_n_sync;
reg [1:0] controller_addr_strobe_n_sync;
reg [1:0] adv_sync;
reg [1:0] bwe_sync;
reg [1:0] gw_sync;
reg [1:0] mode_sync;
reg [1:0] sleep_sync;
reg [1:0] drive_sync;
wire [`SBSC_LANES-1:0] lane_s2;
reg [`SBSC_ADDR_W-1:0] addr_s1;
reg [`SBSC_ADDR_W-1:0] addr_s2;
reg [`SBSC_DATA_W-1:0] din_s1;
reg [`SBSC_DATA_W-1:0] din_s2;

// Timing through the front end, counted in rising edges from a pin change:
//   edge 1 and 2: the two synchroniser stages take the new level
//   edge 3: the access registers act on it (load, advance or sleep)
// Every control pin except output enable, and the address and data buses share this depth,
// so a strobe always meets the address that was presented with it.
// The cost is two cycles of latency on every access; a master that
// needs the bare flow-through timing of the pins cannot use this block.
//
// The sleep level and the flag that says the sleep pin is driven are
// synchronised on their own and combined after the second stage, so a
// glitch of the combination never enters a synchroniser.
// Reset levels are the idle levels of the pins, so no strobe is seen as reset lifts.
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ce_a_sync <= 2'h3;
        ce_b_sync <= 2'h0;
        ce_c_sync <= 2'h3;
        processor_addr_strobe_n_sync <= 2'h3;
        controller_addr_strobe_n_sync <= 2'h3;
        adv_sync <= 2'h3;
        bwe_sync <= 2'h3;
        gw_sync <= 2'h3;
        mode_sync <= 2'h0;
        sleep_sync <= 2'h0;
        drive_sync <= 2'h0;
        addr_s1 <= `SBSC_RST_ADDR;
        addr_s2 <= `SBSC_RST_ADDR;
        din_s1 <= `SBSC_RST_DATA;
        din_s2 <= `SBSC_RST_DATA;
    end
    else
    begin
        ce_a_sync <= {ce_a_sync[0], chip_select_a_n};
        ce_b_sync <= {ce_b_sync[0], chip_select_b};
        ce_c_sync <= {ce_c_sync[0], chip_select_c_n};
        processor_addr_strobe_n_sync <= {processor_addr_strobe_n_sync[0], processor_addr_strobe_n};
        controller_addr_strobe_n_sync <= {controller_addr_strobe_n_sync[0], controller_addr_strobe_n};
        adv_sync <= {adv_sync[0], burst_advance_n};
        bwe_sync <= {bwe_sync[0], byte_write_enable_n};
        gw_sync <= {gw_sync[0], global_write_n};
        mode_sync <= {mode_sync[0], burst_mode_interleaved};
        sleep_sync <= {sleep_sync[0], sleep_request};
        drive_sync <= {drive_sync[0], sleep_request_driven};
        addr_s1 <= addr_in;
        addr_s2 <= addr_s1;
        din_s1 <= data_in;
        din_s2 <= din_s1;
    end
end

// Per-lane write selects: one two-stage synchroniser for each byte lane,
// reset to the idle (no write) level so no lane writes straight after reset
genvar lane_idx;
generate
    for (lane_idx = 0; lane_idx < `SBSC_LANES; lane_idx = lane_idx + 1)
    begin : g_lane_sync
        reg [1:0] lane_sync_reg;

        always @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
                lane_sync_reg <= 2'h3;
            else
                lane_sync_reg <= {lane_sync_reg[0], byte_lane_write_n[lane_idx]};
        end

        assign lane_s2[lane_idx] = lane_sync_reg[1];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Strobe decode and select decision
wire ce_a_n = ce_a_sync[1];
wire ce_b = ce_b_sync[1];
wire ce_c_n = ce_c_sync[1];
// Processor strobe needs the first select low at the same edge; the
// controller strobe stands back whenever the processor strobe is taken.
// With the first select high only the controller strobe can load, and
// that load then counts as a deselect.
wire processor_addr_strobe_n_hit = ~processor_addr_strobe_n_sync[1] & ~ce_a_n;
wire controller_addr_strobe_n_hit = ~controller_addr_strobe_n_sync[1] & ~processor_addr_strobe_n_hit;
wire addr_load = processor_addr_strobe_n_hit | controller_addr_strobe_n_hit;
// Selects count only at an address load; otherwise they are don't-care
wire sel_now = ~ce_a_n & ce_b & ~ce_c_n;
// Write class: global write forces all lanes, byte write uses lane selects
wire gw_act = ~gw_sync[1];
wire bwe_act = ~bwe_sync[1];
wire [`SBSC_LANES-1:0] lanes_now = gw_act ? 4'hF : (bwe_act ? ~lane_s2 : 4'h0);
// Processor strobe starts a read only; writes come on following cycles
wire is_write = ~processor_addr_strobe_n_hit & (gw_act | (|lanes_now));
wire advance = ~adv_sync[1];
// Undriven sleep pin reads as low, as an internal pull-down would give
wire sleeping = sleep_sync[1] & drive_sync[1];

////////////////////////////////////////////////////////////////////////////////
// Address, burst counter and access state
reg [`SBSC_ADDR_W-1:0] base_addr_reg;
reg [`SBSC_BURST_W-1:0] burst_cnt_reg;
reg [`SBSC_BURST_W-1:0] burst_cnt_next;
reg selected_reg;
reg desel_prev_reg;
reg first_read_reg;
reg [`SBSC_BURST_W-1:0] burst_offset;
reg [`SBSC_BURST_W-1:0] burst_offset_next;

// Interleaved order flips bits of the start offset; linear order adds
// and wraps within the group of four. Both the offset now and the one
// after an advance are formed here so the clocked block only selects.
always @*
begin
    burst_cnt_next = burst_cnt_reg + 2'h1;
    if (mode_sync[1])
    begin
        burst_offset = base_addr_reg[1:0] ^ burst_cnt_reg;
        burst_offset_next = base_addr_reg[1:0] ^ burst_cnt_next;
    end
    else
    begin
        burst_offset = base_addr_reg[1:0] + burst_cnt_reg;
        burst_offset_next = base_addr_reg[1:0] + burst_cnt_next;
    end
end

// Priority on each edge, highest first:
//   sleep: no access starts and the access outputs go idle
//   address load: selects are judged, address and counter are reloaded
//   burst continue: advance steps the counter while the device is selected
//   otherwise: deselected and idle
// Address and counter survive sleep untouched, so a burst cut by sleep
// carries on from where it stood once the pin falls again; the master
// must not rely on any access timing while the pin is high.
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        base_addr_reg <= `SBSC_RST_ADDR;
        burst_cnt_reg <= `SBSC_RST_BURST;
        selected_reg <= 1'b0;
        desel_prev_reg <= 1'b1;
        first_read_reg <= 1'b0;
        mem_addr_reg <= `SBSC_RST_ADDR;
        write_data_reg <= `SBSC_RST_DATA;
        lane_write_reg <= `SBSC_RST_LANES;
        access_valid_reg <= 1'b0;
        access_write_reg <= 1'b0;
        sleep_active_reg <= 1'b0;
    end
    else
    begin
        // Sleep gates new accesses and bursts in progress alike; stored contents are untouched
        sleep_active_reg <= sleeping;
        first_read_reg <= 1'b0;
        if (sleeping)
        begin
            access_valid_reg <= 1'b0;
            access_write_reg <= 1'b0;
            lane_write_reg <= `SBSC_RST_LANES;
        end
        else if (addr_load)
        begin
            // Selects are looked at on this edge and nowhere else
            selected_reg <= sel_now;
            base_addr_reg <= addr_s2;
            burst_cnt_reg <= `SBSC_RST_BURST;
            mem_addr_reg <= addr_s2;
            access_valid_reg <= sel_now;
            access_write_reg <= sel_now & is_write;
            // Lane selects only qualify writes; a read leaves every lane idle
            lane_write_reg <= (sel_now & is_write) ? lanes_now : `SBSC_RST_LANES;
            write_data_reg <= din_s2;
            first_read_reg <= sel_now & ~is_write & desel_prev_reg;
            desel_prev_reg <= ~sel_now;
        end
        else if (selected_reg)
        begin
            // Burst continue or write data phase; advance steps the counter
            if (advance)
            begin
                burst_cnt_reg <= burst_cnt_next;
                mem_addr_reg <= {base_addr_reg[`SBSC_ADDR_W-1:2], burst_offset_next};
            end
            else
            begin
                mem_addr_reg <= {base_addr_reg[`SBSC_ADDR_W-1:2], burst_offset};
            end
            access_valid_reg <= 1'b1;
            access_write_reg <= is_write;
            lane_write_reg <= is_write ? lanes_now : `SBSC_RST_LANES;
            write_data_reg <= din_s2;
        end
        else
        begin
            access_valid_reg <= 1'b0;
            access_write_reg <= 1'b0;
            lane_write_reg <= `SBSC_RST_LANES;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Output drive; enable is asynchronous so the pin is used directly here,
// never a synchroniser stage, trading metastability for the documented
// combinational path from output enable to the data pins
reg [`SBSC_DATA_W-1:0] dout_reg;

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
        dout_reg <= `SBSC_RST_DATA;
    else
        dout_reg <= read_data;
end

assign data_out = dout_reg;

// A read phase drives only while selected, valid and not writing; the
// write data phase floats the pins whatever output enable says
wire read_phase = selected_reg & access_valid_reg & ~access_write_reg;

// The first clock of a read out of deselect keeps the pins floating
wire read_masked = first_read_reg;

// Output enable itself acts without waiting for a clock edge
assign data_oe = ~output_enable_n & read_phase & ~read_masked;

endmodule // sbsc_bus_control
`default_nettype wire

// ---- sbsc_checker.sv ----
// Concurrent checks on the bus control pins
`timescale 1ns/10ps
`default_nettype none
`include "sbsc_defs.vh"
module sbsc_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic sleep_request_driven,
    input wire logic [`SBSC_ADDR_W-1:0] addr_in,
    input wire logic data_oe,
    input wire logic [`SBSC_ADDR_W-1:0] mem_addr_reg,
    input wire logic access_valid_reg,
    input wire logic access_write_reg,
    input wire logic sleep_active_reg
);
    // Pin decode; holds of four edges cover the two-flop input sync
    wire logic sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    wire logic doze = sleep_request && sleep_request_driven;
    wire logic pld = !processor_addr_strobe_n && !chip_select_a_n && !doze;
    wire logic cld = !controller_addr_strobe_n && processor_addr_strobe_n && !doze;
    wire logic ign = pld == 1'b0 && chip_select_a_n && controller_addr_strobe_n && burst_advance_n;
    wire logic hit = access_valid_reg && mem_addr_reg == addr_in;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    property p_oe; output_enable_n |-> !data_oe; endproperty
    a_oe: assert property (p_oe) else $error("data driven");
    property p_pld; (pld && sel && $stable(addr_in))[*4] |-> hit; endproperty
    a_pld: assert property (p_pld) else $error("no load");
    property p_prd; (pld && sel)[*4] |-> !access_write_reg; endproperty
    a_prd: assert property (p_prd) else $error("not read");
    property p_cld; (cld && sel && $stable(addr_in))[*4] |-> hit; endproperty
    a_cld: assert property (p_cld) else $error("no load");
    property p_ign; ign[*4] |-> $stable(mem_addr_reg); endproperty
    a_ign: assert property (p_ign) else $error("moved");
    property p_des; (cld && !sel)[*4] |-> !access_valid_reg; endproperty
    a_des: assert property (p_des) else $error("selected");
    property p_doze; doze[*4] |-> sleep_active_reg && !access_valid_reg; endproperty
    a_doze: assert property (p_doze) else $error("awake");
    property p_pull; (!sleep_request_driven)[*4] |-> !sleep_active_reg; endproperty
    a_pull: assert property (p_pull) else $error("asleep");
    c_pld: cover property (pld && sel);
    c_doze: cover property (sleep_active_reg);
    c_adv: cover property (!burst_advance_n && access_valid_reg);
endmodule // sbsc_checker
bind sbsc_bus_control sbsc_checker sbsc_checker_i (.core_clk, .rst_n, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .output_enable_n, .sleep_request, .sleep_request_driven, .addr_in,
    .data_oe, .mem_addr_reg, .access_valid_reg, .access_write_reg, .sleep_active_reg);
`default_nettype wire

// ---- sbsc_master.sv ----
// Bus master model driving the request pins
`timescale 1ns/10ps
`default_nettype none
module sbsc_master (
    input wire logic core_clk,
    input wire logic [13:0] req,
    output var logic [13:0] pins = 14'h2FFA
);
    // Launch after the edge and hold; an undriven sleep pin sits at its pull-down
    always @(posedge core_clk)
        pins <= {req[13], req[12] & req[13], req[11:0]};
endmodule // sbsc_master
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the bus control front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [13:0] IDLE = 14'h2FFA;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic oe_n = 1'b1;
    logic mode = 1'b0;
    logic [13:0] req = IDLE;
    logic [20:0] addr = 21'h000000;
    logic [20:0] last = 21'h000000;
    logic [35:0] wd = 36'h000000000;
    logic [31:0] seed = 32'h0000F96B;
    logic gone = 1'b1; // Last load was a deselect: next read's first clock is masked
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    wire logic [13:0] pins;
    wire logic [35:0] wreg;
    wire logic [35:0] dout;
    wire logic [20:0] maddr;
    wire logic [3:0] lanes;
    wire logic oe, valid, wr, slp;
    ////////////////////////////////////////////////////////////////////////////////
    sbsc_master sbsc_master_i (.core_clk(core_clk), .req(req), .pins(pins));
    sbsc_bus_control sbsc_bus_control_i (.core_clk(core_clk), .rst_n(rst_n),
        .chip_select_a_n(pins[0]), .chip_select_b(pins[1]), .chip_select_c_n(pins[2]),
        .processor_addr_strobe_n(pins[3]), .controller_addr_strobe_n(pins[4]),
        .burst_advance_n(pins[5]), .byte_write_enable_n(pins[6]), .byte_lane_write_n(pins[10:7]),
        .global_write_n(pins[11]), .output_enable_n(oe_n), .burst_mode_interleaved(mode),
        .sleep_request(pins[12]), .sleep_request_driven(pins[13]), .addr_in(addr), .data_in(wd),
        .read_data(~wd), .data_out(dout), .data_oe(oe), .mem_addr_reg(maddr), .write_data_reg(wreg),
        .lane_write_reg(lanes), .access_valid_reg(valid), .access_write_reg(wr),
        .sleep_active_reg(slp));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a hang cannot stall the run
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            close_out();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Offset after k steps: interleaved flips bits, linear wraps within four
    function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] k, input logic m);
        return m ? s ^ k : s + k;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // ld: 0 ignored, 1 loaded, 2 deselected, 3 asleep; idle gap keeps old strobes off new address
    task automatic run(input logic [13:0] m, input logic [1:0] ld, input logic w, input logic [3:0] ln);
        step(4);
        seed = lfsr(seed);
        req <= IDLE ^ m;
        addr <= seed[20:0];
        wd <= {seed[3:0], seed};
        oe_n <= seed[5] & ~gone;
        step(4);
        #1;
        if (ld != 2'd0) chk(oe, !oe_n && ld == 2'd1 && !w && !gone);
        step(2);
        #1;
        chk(maddr, ld == 2'd1 || ld == 2'd2 ? addr : last);
        if (ld != 2'd0) chk(valid, ld == 2'd1);
        if (ld == 2'd1) chk(wr, w);
        if (ld == 2'd1) chk(lanes, ln);
        if (ld == 2'd1) chk(wreg & {36{w}}, wd & {36{w}});
        chk(dout, ~wd);
        chk(slp, ld == 2'd3);
        if (ld != 2'd0 || oe_n) chk(oe, !oe_n && ld == 2'd1 && !w);
        if (ld == 2'd1 || ld == 2'd2) last = addr;
        if (ld == 2'd1 || ld == 2'd2) gone = (ld == 2'd2);
        $display("test %h done", m);
        @(posedge core_clk);
        req <= IDLE;
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Strobe, select, write and sleep cases, then a three-step burst in each mode
    initial
    begin
        step(5);
        rst_n <= 1'b1;
        run(14'h0008, 2'd1, 1'b0, 4'h0);
        run(14'h0009, 2'd0, 1'b0, 4'h0);
        run(14'h0818, 2'd1, 1'b0, 4'h0);
        run(14'h0810, 2'd1, 1'b1, 4'hF);
        run(14'h02D0, 2'd1, 1'b1, 4'h5);
        run(14'h0012, 2'd2, 1'b0, 4'h0);
        run(14'h0014, 2'd2, 1'b0, 4'h0);
        run(14'h0011, 2'd2, 1'b0, 4'h0);
        run(14'h1010, 2'd3, 1'b0, 4'h0);
        run(14'h3010, 2'd1, 1'b0, 4'h0);
        for (int md = 0; md < 2; md++)
        begin
            mode <= md[0];
            run(14'h0008, 2'd1, 1'b0, 4'h0);
            for (int k = 1; k < 4; k++)
            begin
                step(4);
                req <= IDLE ^ 14'h0021;
                step(1);
                req <= IDLE;
                step(5);
                #1;
                chk(maddr, {last[20:2], nxt(last[1:0], k[1:0], md[0])});
            end
            $display("burst mode %0d done", md);
        end
        close_out();
    end
endmodule // tb_top
`default_nettype wire
